// *** hw/lpw_pkg.sv ***
// shared constants for the low-power wake selector and radio domain gating
package lpw_pkg;

   // application core low-power states, one-hot
   typedef enum logic [6:0] {
      LPW_ACTIVE      = 7'h01,
      LPW_PERIPH_ONLY = 7'h02,
      LPW_LV_STANDBY  = 7'h04,
      LPW_WFI_STANDBY = 7'h08,
      LPW_SLEEP       = 7'h10,
      LPW_DEEP_SLEEP  = 7'h20,
      LPW_WAKING      = 7'h40
   } lpw_core_state_type;

   // requested core low-power state codes on core_state_req
   localparam logic [2:0] LPW_REQ_NONE        = 3'h0;
   localparam logic [2:0] LPW_REQ_PERIPH_ONLY = 3'h1;
   localparam logic [2:0] LPW_REQ_LV_STANDBY  = 3'h2;
   localparam logic [2:0] LPW_REQ_WFI_STANDBY = 3'h3;
   localparam logic [2:0] LPW_REQ_SLEEP       = 3'h4;
   localparam logic [2:0] LPW_REQ_DEEP_SLEEP  = 3'h5;

   // network processor modes on net_mode
   localparam logic [2:0] LPW_NET_ACTIVE      = 3'h0;
   localparam logic [2:0] LPW_NET_TRANSMIT    = 3'h1;
   localparam logic [2:0] LPW_NET_RECEIVE     = 3'h2;
   localparam logic [2:0] LPW_NET_LISTEN      = 3'h3;
   localparam logic [2:0] LPW_NET_ULP_RETAIN  = 3'h4;
   localparam logic [2:0] LPW_NET_ULP_NORET   = 3'h5;

   // wake source bit positions
   localparam int LPW_SRC_DEEP_SLEEP_TIMER = 0;
   localparam int LPW_SRC_WIRELESS         = 1;
   localparam int LPW_SRC_GPIO             = 2;
   localparam int LPW_SRC_COMPARATOR       = 3;
   localparam int LPW_SRC_SYSTEM_RTC       = 4;
   localparam int LPW_SRC_ALARM            = 5;
   localparam int LPW_SRC_SECONDS          = 6;
   localparam int LPW_SRC_MILLISECOND      = 7;
   localparam int LPW_SRC_WATCHDOG         = 8;
   localparam int LPW_SRC_SENSOR_COLLECTOR = 9;
   localparam int LPW_SRC_LOW_POWER_TIMER  = 10;
   localparam int LPW_SRC_NUM              = 11;

   // permit masks per state class
   localparam logic [10:0] LPW_PERMIT_ALWAYS  = 11'h1ff;
   localparam logic [10:0] LPW_PERMIT_PERIPH  = 11'h7ff;
   localparam logic [10:0] LPW_PERMIT_NONE    = 11'h000;

   // power domain vector bit positions
   localparam int LPW_DOM_BBP_TX    = 0;
   localparam int LPW_DOM_BBP_RX    = 1;
   localparam int LPW_DOM_BBP_PKT   = 2;
   localparam int LPW_DOM_AFE_TX    = 3;
   localparam int LPW_DOM_AFE_RX    = 4;
   localparam int LPW_DOM_AFE_PKT   = 5;
   localparam int LPW_DOM_RF_TX     = 6;
   localparam int LPW_DOM_RF_RX     = 7;
   localparam int LPW_DOM_NET_CPU   = 8;
   localparam int LPW_DOM_SECURITY  = 9;
   localparam int LPW_DOM_NUM       = 10;

   localparam logic [9:0] LPW_DOM_ALL      = 10'h3ff;
   localparam logic [9:0] LPW_DOM_TRANSMIT = 10'h36d;
   localparam logic [9:0] LPW_DOM_RECEIVE  = 10'h3b6;
   localparam logic [9:0] LPW_DOM_LISTEN   = 10'h392;
   localparam logic [9:0] LPW_DOM_ULP      = 10'h000;

   // domain vector after reset: network processor active
   localparam logic [9:0] LPW_DOM_RESET    = 10'h3ff;

endpackage : lpw_pkg

// *** hw/lpw_wake_selector.sv ***
// wake qualification for the core and power domain gating for the network processor
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Always-on sources wake the core from every listed low-power state except wait-for-interrupt standby.
// - Sensor collector and low-power timer wake only peripheral-only and low-voltage standby states.
// - Detector and peripheral interrupts never wake from low-voltage standby, sleep or deep sleep.
// - Network active state powers every network processor domain.
// - Transmit mode powers everything except receive sections of baseband, front ends.
// - Receive mode turns off transmit sections of baseband and both front ends.
// - Listen additionally gates packet parts of baseband and analog front end.
// - Ultra-low-power turns off modem, network processor, security; power unit rules rest.
// - Retaining variant holds network RAM and execution state through sleep.
// - Non-retaining variant drops RAM; wake starts from fresh uninitialised condition.
// - Wait-for-interrupt standby wakes on any interrupt.
// - Only enabled sources leave low-voltage standby, sleep or shutdown.
module lpw_wake_selector
   import lpw_pkg::*;
#(
   parameter int NUM_IRQ = 32
) (
   // clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst_b,
   // core power state control from power management logic
   input  wire logic [2:0]               core_state_req,
   input  wire logic                     core_state_load,
   input  wire logic [LPW_SRC_NUM-1:0]   wake_enable,
   // asynchronous wake event sources
   input  wire logic [LPW_SRC_NUM-1:0]   wake_source,
   input  wire logic [NUM_IRQ-1:0]       core_irq,
   // network processor mode control
   input  wire logic [2:0]               net_mode,
   // core wake outputs
   output logic                          wake_req,
   output logic [LPW_SRC_NUM-1:0]        wake_cause,
   output lpw_core_state_type            core_state,
   // network processor domain outputs
   output logic [LPW_DOM_NUM-1:0]        net_domain_on,
   output logic                          net_ram_retain,
   output logic                          net_cold_start,
   output logic                          pmu_owns_chip
);

   // elaboration checks; the package masks are sized for these counts,
   // so a different source or domain count would silently misalign them
   if (NUM_IRQ < 1) begin : g_check_irq
      $error("NUM_IRQ must be at least 1");
   end
   if (LPW_SRC_NUM != 11) begin : g_check_src
      $error("wake source count does not match the permit masks");
   end
   if (LPW_DOM_NUM != 10) begin : g_check_dom
      $error("domain count does not match the domain masks");
   end

   // two-stage synchronisers, one pass per line; only the second stage
   // feeds logic, the first may still be settling
   wire [LPW_SRC_NUM-1:0] src_sync;
   wire [NUM_IRQ-1:0]     irq_sync;

   for (genvar i = 0; i < LPW_SRC_NUM; i++) begin : g_src_sync
      logic meta;
      logic sync;

      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            meta <= 1'b0;
            sync <= 1'b0;
         end else begin
            meta <= wake_source[i];
            sync <= meta;
         end
      end

      assign src_sync[i] = sync;
   end

   for (genvar j = 0; j < NUM_IRQ; j++) begin : g_irq_sync
      logic meta;
      logic sync;

      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            meta <= 1'b0;
            sync <= 1'b0;
         end else begin
            meta <= core_irq[j];
            sync <= meta;
         end
      end

      assign irq_sync[j] = sync;
   end

   // permitted sources for the present state
   // sleep and deep sleep share one set; the two peripheral-class sources stay out
   logic [LPW_SRC_NUM-1:0] permit;
   always_comb begin
      case (core_state)
         LPW_PERIPH_ONLY: permit = LPW_PERMIT_PERIPH;
         LPW_LV_STANDBY:  permit = LPW_PERMIT_PERIPH;
         LPW_SLEEP:       permit = LPW_PERMIT_ALWAYS;
         LPW_DEEP_SLEEP:  permit = LPW_PERMIT_ALWAYS;
         default:         permit = LPW_PERMIT_NONE;
      endcase
   end

   wire [LPW_SRC_NUM-1:0] qualified = src_sync & wake_enable & permit;
   wire                   any_irq   = |irq_sync;
   // wfi standby listens to the interrupt lines only; wake_source has no say there
   wire                   wfi_wake  = (core_state == LPW_WFI_STANDBY) && any_irq;
   wire                   src_wake  = |qualified;

   // state request decode
   lpw_core_state_type req_state;
   always_comb begin
      case (core_state_req)
         LPW_REQ_PERIPH_ONLY: req_state = LPW_PERIPH_ONLY;
         LPW_REQ_LV_STANDBY:  req_state = LPW_LV_STANDBY;
         LPW_REQ_WFI_STANDBY: req_state = LPW_WFI_STANDBY;
         LPW_REQ_SLEEP:       req_state = LPW_SLEEP;
         LPW_REQ_DEEP_SLEEP:  req_state = LPW_DEEP_SLEEP;
         default:             req_state = LPW_ACTIVE;
      endcase
   end

   // core state machine; waking holds one cycle so the pulse is clean
   lpw_core_state_type next_core_state;
   always_comb begin
      case (core_state)
         LPW_ACTIVE:
            next_core_state = core_state_load ? req_state : LPW_ACTIVE;
         LPW_PERIPH_ONLY, LPW_LV_STANDBY, LPW_SLEEP, LPW_DEEP_SLEEP:
            next_core_state = src_wake ? LPW_WAKING : core_state;
         LPW_WFI_STANDBY:
            next_core_state = wfi_wake ? LPW_WAKING : LPW_WFI_STANDBY;
         LPW_WAKING:
            next_core_state = LPW_ACTIVE;
         default:
            next_core_state = LPW_ACTIVE;
      endcase
   end

   // the pulse and the waking state rise on the same edge
   wire next_wake_req = (next_core_state == LPW_WAKING);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         core_state <= LPW_ACTIVE;
      end else begin
         core_state <= next_core_state;
      end
   end

   // cause is captured with the pulse and held, so it can be read late
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wake_req   <= 1'b0;
         wake_cause <= '0;
      end else begin
         wake_req   <= next_wake_req;
         if (next_wake_req)
            wake_cause <= qualified;
      end
   end

   // network processor domain gating
   logic [LPW_DOM_NUM-1:0] next_domain;
   always_comb begin
      case (net_mode)
         LPW_NET_ACTIVE:     next_domain = LPW_DOM_ALL;
         LPW_NET_TRANSMIT:   next_domain = LPW_DOM_TRANSMIT;
         LPW_NET_RECEIVE:    next_domain = LPW_DOM_RECEIVE;
         LPW_NET_LISTEN:     next_domain = LPW_DOM_LISTEN;
         LPW_NET_ULP_RETAIN: next_domain = LPW_DOM_ULP;
         LPW_NET_ULP_NORET:  next_domain = LPW_DOM_ULP;
         default:            next_domain = LPW_DOM_ALL;
      endcase
   end

   // network mode decode
   wire net_is_retain   = (net_mode == LPW_NET_ULP_RETAIN);
   wire net_is_noret    = (net_mode == LPW_NET_ULP_NORET);
   wire net_in_ulp      = net_is_retain || net_is_noret;
   wire next_ram_retain = !net_is_noret;

   // cold start flag: set in the non-retaining sleep, kept through a hop to the
   // retaining one, and spent on the first cycle outside sleep
   logic net_lost_state;
   wire  next_lost_state = net_is_noret ? 1'b1 :
                           net_in_ulp   ? net_lost_state : 1'b0;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         net_domain_on  <= LPW_DOM_RESET;
         net_ram_retain <= 1'b1;
         pmu_owns_chip  <= 1'b0;
      end else begin
         net_domain_on  <= next_domain;
         net_ram_retain <= next_ram_retain;
         pmu_owns_chip  <= net_in_ulp;
      end
   end

   // leaving sleep for any mode, not only active, still needs the restart
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         net_lost_state <= 1'b0;
         net_cold_start <= 1'b0;
      end else begin
         net_lost_state <= next_lost_state;
         // one-cycle pulse on leaving the non-retaining sleep
         net_cold_start <= net_lost_state && !net_in_ulp;
      end
   end

endmodule : lpw_wake_selector

`default_nettype wire

// *** sim/lpw_wake_selector_monitor.sv ***
// port checker for the wake selector
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_selector_monitor
   import lpw_pkg::*;
#(
   parameter int NUM_IRQ = 32
) (
   // all ports of the selector
   input wire logic                   sys_clk,
   input wire logic                   rst_b,
   input wire logic [2:0]             core_state_req,
   input wire logic                   core_state_load,
   input wire logic [LPW_SRC_NUM-1:0] wake_enable,
   input wire logic [LPW_SRC_NUM-1:0] wake_source,
   input wire logic [NUM_IRQ-1:0]     core_irq,
   input wire logic [2:0]             net_mode,
   input wire logic                   wake_req,
   input wire logic [LPW_SRC_NUM-1:0] wake_cause,
   input wire lpw_core_state_type     core_state,
   input wire logic [LPW_DOM_NUM-1:0] net_domain_on,
   input wire logic                   net_ram_retain,
   input wire logic                   net_cold_start,
   input wire logic                   pmu_owns_chip
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_noret_exit;
      net_mode == LPW_NET_ULP_NORET ##1 net_mode == LPW_NET_ACTIVE;
   endsequence
   sequence s_return;
      core_state == LPW_WAKING ##1 (core_state == LPW_ACTIVE && !wake_req);
   endsequence
   property p_act; net_mode == LPW_NET_ACTIVE |=> net_domain_on == 10'h3ff; endproperty
   a_act: assert property (p_act) else $error("active mode domains wrong");
   property p_tx; net_mode == LPW_NET_TRANSMIT |=> net_domain_on == 10'h36d; endproperty
   a_tx: assert property (p_tx) else $error("transmit mode domains wrong");
   property p_retain; net_mode == LPW_NET_ULP_RETAIN |=> net_ram_retain; endproperty
   a_retain: assert property (p_retain) else $error("retention lost in retaining sleep");
   property p_cold_once; net_cold_start |=> !net_cold_start; endproperty
   a_cold_once: assert property (p_cold_once) else $error("cold start longer than one cycle");
   property p_rx; net_mode == LPW_NET_RECEIVE |=> net_domain_on == 10'h3b6; endproperty
   a_rx: assert property (p_rx) else $error("receive mode domains wrong");
   property p_listen; net_mode == LPW_NET_LISTEN |=> net_domain_on == 10'h392; endproperty
   a_listen: assert property (p_listen) else $error("listen mode domains wrong");
   property p_ulp; net_mode inside {3'h4, 3'h5} |=> net_domain_on == 10'h000 && pmu_owns_chip; endproperty
   a_ulp: assert property (p_ulp) else $error("ulp mode domains wrong");
   property p_noret; net_mode == LPW_NET_ULP_NORET |=> !net_ram_retain; endproperty
   a_noret: assert property (p_noret) else $error("retention kept in mode 5");
   property p_cold; s_noret_exit |=> net_cold_start ##1 !net_cold_start; endproperty
   a_cold: assert property (p_cold) else $error("cold start pulse wrong");
   property p_wake; wake_req |-> s_return; endproperty
   a_wake: assert property (p_wake) else $error("wake return order wrong");
   property p_load;
      core_state == LPW_ACTIVE && core_state_load && core_state_req == LPW_REQ_SLEEP |=> core_state == LPW_SLEEP;
   endproperty
   a_load: assert property (p_load) else $error("sleep request not taken");
   property p_deep; wake_req && $past(core_state) inside {LPW_SLEEP, LPW_DEEP_SLEEP} |-> wake_cause[10:9] == 2'h0;
   endproperty
   a_deep: assert property (p_deep) else $error("sleep woken by peripheral source");
   property p_enable; wake_req |-> (wake_cause & ~$past(wake_enable)) == 11'h000; endproperty
   a_enable: assert property (p_enable) else $error("wake by disabled source");
   property p_wfi; wake_req && $past(core_state) == LPW_WFI_STANDBY |-> wake_cause == 11'h000; endproperty
   a_wfi: assert property (p_wfi) else $error("wfi wake cause not zero");
   property p_cause; wake_req && $past(core_state) != LPW_WFI_STANDBY |-> wake_cause != 11'h000; endproperty
   a_cause: assert property (p_cause) else $error("wake without cause");
endmodule : lpw_wake_selector_monitor
bind lpw_wake_selector lpw_wake_selector_monitor #(.NUM_IRQ(NUM_IRQ)) u_mon (.sys_clk(sys_clk), .rst_b(rst_b),
   .core_state_req(core_state_req), .core_state_load(core_state_load), .wake_enable(wake_enable),
   .wake_source(wake_source), .core_irq(core_irq), .net_mode(net_mode), .wake_req(wake_req),
   .wake_cause(wake_cause), .core_state(core_state), .net_domain_on(net_domain_on),
   .net_ram_retain(net_ram_retain), .net_cold_start(net_cold_start), .pmu_owns_chip(pmu_owns_chip));
`default_nettype wire

// *** sim/lpw_source_model.sv ***
// wake event sources as level signals
`timescale 1ns/1ps
`default_nettype none
module lpw_source_model
   import lpw_pkg::*;
(
   // control from the bench
   input  wire logic                   sys_clk,
   input  wire logic                   fire,
   input  wire logic [LPW_SRC_NUM-1:0] fire_src,
   input  wire logic                   fire_irq,
   // event lines
   output logic      [LPW_SRC_NUM-1:0] wake_source,
   output logic      [31:0]            core_irq
);
   // events are levels that stay up while fire is held, so a slow wake still sees them
   always @(negedge sys_clk) begin
      wake_source <= fire ? fire_src : 11'h000;
      core_irq    <= {31'h0, fire && fire_irq};
   end
endmodule : lpw_source_model
`default_nettype wire

// *** sim/lpw_wake_selector_bench.sv ***
// self-checking bench for the wake selector
`timescale 1ns/1ps
`default_nettype none
module lpw_wake_selector_bench;
   import lpw_pkg::*;
   logic               sys_clk, rst_b, core_state_load, fire, fire_irq;
   logic               wake_req, net_ram_retain, net_cold_start, pmu_owns_chip;
   logic [2:0]         core_state_req, net_mode;
   logic [10:0]        wake_enable, wake_source, fire_src, wake_cause;
   logic [31:0]        core_irq;
   logic [9:0]         net_domain_on;
   lpw_core_state_type core_state;
   int                 miscompares, cmp_count, cycles;
   lpw_wake_selector u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .core_state_req(core_state_req),
      .core_state_load(core_state_load), .wake_enable(wake_enable), .wake_source(wake_source),
      .core_irq(core_irq), .net_mode(net_mode), .wake_req(wake_req), .wake_cause(wake_cause),
      .core_state(core_state), .net_domain_on(net_domain_on), .net_ram_retain(net_ram_retain),
      .net_cold_start(net_cold_start), .pmu_owns_chip(pmu_owns_chip));
   lpw_source_model u_src (.sys_clk(sys_clk), .fire(fire), .fire_src(fire_src), .fire_irq(fire_irq),
      .wake_source(wake_source), .core_irq(core_irq));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic check(string what, logic [10:0] exp, logic [10:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic t_net(logic [2:0] m, logic [9:0] dom, logic cold);
      net_mode = m;
      @(negedge sys_clk);
      check("domains", {1'b0, dom}, {1'b0, net_domain_on});
      check("retain", {10'h0, m != LPW_NET_ULP_NORET}, {10'h0, net_ram_retain});
      check("pmu", {10'h0, m inside {3'h4, 3'h5}}, {10'h0, pmu_owns_chip});
      check("cold", {10'h0, cold}, {10'h0, net_cold_start});
   endtask : t_net
   // src below zero means a plain interrupt
   task automatic t_wake(logic [2:0] req, int src, logic [10:0] en, logic exp);
      logic seen;
      seen = 1'b0;
      wake_enable = en;
      core_state_req = req;
      core_state_load = 1'b1;
      @(negedge sys_clk);
      core_state_load = 1'b0;
      fire_irq = src < 0;
      fire_src = src < 0 ? 11'h000 : 11'h001 << src;
      fire = 1'b1;
      repeat (8) begin
         @(negedge sys_clk);
         seen |= wake_req;
      end
      check("wake", {10'h0, exp}, {10'h0, seen});
      if (exp)
         check("cause", fire_src, wake_cause);
      // refused wake: fire a permitted source so the core returns to active
      if (!exp) begin
         wake_enable = 11'h001;
         fire_src = 11'h001;
         repeat (8) @(negedge sys_clk);
      end
      fire = 1'b0;
      repeat (4) @(negedge sys_clk);
      check("state", {4'h0, LPW_ACTIVE}, {4'h0, core_state});
   endtask : t_wake
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         end_sim();
      end
   end
   initial begin
      logic [2:0] reqs [4];
      reqs = '{LPW_REQ_PERIPH_ONLY, LPW_REQ_LV_STANDBY, LPW_REQ_SLEEP, LPW_REQ_DEEP_SLEEP};
      rst_b = 1'b0;
      {core_state_load, fire, fire_irq} = 3'h0;
      {core_state_req, net_mode, wake_enable, fire_src} = 28'h0;
      {miscompares, cmp_count, cycles} = 0;
      repeat (20) @(negedge sys_clk);
      rst_b = 1'b1;
      t_net(LPW_NET_ACTIVE, 10'h3ff, 1'b0);
      t_net(LPW_NET_TRANSMIT, 10'h36d, 1'b0);
      t_net(LPW_NET_RECEIVE, 10'h3b6, 1'b0);
      t_net(LPW_NET_LISTEN, 10'h392, 1'b0);
      t_net(LPW_NET_ULP_NORET, 10'h000, 1'b0);
      t_net(LPW_NET_ACTIVE, 10'h3ff, 1'b1);
      t_net(LPW_NET_ULP_RETAIN, 10'h000, 1'b0);
      t_net(LPW_NET_ACTIVE, 10'h3ff, 1'b0);
      t_net(LPW_NET_ULP_NORET, 10'h000, 1'b0);
      t_net(LPW_NET_TRANSMIT, 10'h36d, 1'b1);
      t_net(LPW_NET_TRANSMIT, 10'h36d, 1'b0);
      t_net(3'h6, 10'h3ff, 1'b0);
      t_net(LPW_NET_ACTIVE, 10'h3ff, 1'b0);
      for (int r = 0; r < 4; r++)
         for (int s = 0; s < 11; s++)
            t_wake(reqs[r], s, 11'h7ff, s < 9 || r < 2);
      t_wake(LPW_REQ_SLEEP, 0, 11'h7fe, 1'b0);
      t_wake(LPW_REQ_WFI_STANDBY, -1, 11'h000, 1'b1);
      end_sim();
   end
endmodule : lpw_wake_selector_bench
`default_nettype wire
